// file: core/lnb_tone_keying_control.sv
// Module: dual-section tone keying control with lockout and soft-start
//
// Notes on behaviour
// - Wave select and tone on: pin carries the tone
// - Wave select off: pin is envelope
// - Envelope mode: pin held high gives continuous tone
// - Wave mode: output follows pin frequency, duty
// - Wave mode: tone starts about 1 us
// - Wave mode: tone stops 60 us after
// - Below lockout: everything disabled
// - Soft-start ramps to full in 4 ms
// - Two independent section copies
// - Envelope: start 6 us, stop 15-60 us
// - Lockout: settings held zero, commands ignored
`timescale 1ns/1ps
module lnb_tone_keying_control (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// Supply lockout, high while supply is below threshold
	input wire logic i_supply_lockout,
	// Settings write port from the bus interface
	input wire logic i_settings_write,
	input wire logic [tone_keying_pkg::NUM_SECTIONS-1:0] i_external_wave_select,
	input wire logic [tone_keying_pkg::NUM_SECTIONS-1:0] i_tone_output_on,
	// Keying pins, one per section
	input wire logic [tone_keying_pkg::NUM_SECTIONS-1:0] i_tone_keying_pin,
	// Tone onto each supply output
	output logic [tone_keying_pkg::NUM_SECTIONS-1:0] o_lnb_supply_output_tone,
	output logic [tone_keying_pkg::NUM_SECTIONS-1:0] o_tone_active,
	// Settings readback
	output logic [tone_keying_pkg::NUM_SECTIONS-1:0] o_external_wave_select,
	output logic [tone_keying_pkg::NUM_SECTIONS-1:0] o_tone_output_on,
	// Soft-start
	output logic [tone_keying_pkg::RAMP_OUT_W-1:0] o_soft_start_level,
	output logic o_soft_start_done
);
	import tone_keying_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [NUM_SECTIONS-1:0] ext_sel;
		logic [NUM_SECTIONS-1:0] tone_on;
		logic [RAMP_W-1:0] ramp;
		logic ramp_done;
	} top_state_t;

	top_state_t cur;
	top_state_t next_cur;
	logic enable;
	logic [NUM_SECTIONS-1:0] sec_tone;
	logic [NUM_SECTIONS-1:0] sec_active;

	assign enable = ~i_supply_lockout;

	// Settings held at zero and writes dropped under lockout
	always_comb begin
		next_cur = cur;
		if (!enable) begin
			next_cur = '0;
		end else begin
			if (i_settings_write) begin
				next_cur.ext_sel = i_external_wave_select;
				next_cur.tone_on = i_tone_output_on;
			end
			// Fixed ramp, no external setting
			if (cur.ramp >= RAMP_W'(SOFT_START_CYC)) begin
				next_cur.ramp_done = 1'b1;
			end else begin
				next_cur.ramp = cur.ramp + RAMP_ONE;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// ************************************************************
	// Sections
	// ************************************************************
	// One independent copy per output section
	genvar g;
	generate
		for (g = 0; g < NUM_SECTIONS; g++) begin : g_sec
			tone_key_section u_sec (
				.i_sys_clk(i_sys_clk),
				.i_reset(i_reset),
				.i_enable(enable),
				.i_external_wave_select(cur.ext_sel[g]),
				.i_tone_output_on(cur.tone_on[g]),
				.i_tone_keying_pin(i_tone_keying_pin[g]),
				.o_tone(sec_tone[g]),
				.o_tone_active(sec_active[g])
			);
		end
	endgenerate

	assign o_lnb_supply_output_tone = sec_tone;
	assign o_tone_active = sec_active;
	assign o_external_wave_select = cur.ext_sel;
	assign o_tone_output_on = cur.tone_on;
	// Top bits of the ramp count give a coarse level
	assign o_soft_start_level = cur.ramp_done ? {RAMP_OUT_W{1'b1}} :
		cur.ramp[RAMP_W-1 -: RAMP_OUT_W];
	assign o_soft_start_done = cur.ramp_done;

endmodule : lnb_tone_keying_control

// file: core/tone_key_section.sv
// Module: tone keying control for one output section
`timescale 1ns/1ps
module tone_key_section (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// Settings and lockout
	input wire logic i_enable,
	input wire logic i_external_wave_select,
	input wire logic i_tone_output_on,
	// Keying pin
	input wire logic i_tone_keying_pin,
	// Tone to the supply output
	output logic o_tone,
	output logic o_tone_active
);
	import tone_keying_pkg::*;

	typedef struct packed {
		tone_state_t state;
		logic [DLY_W-1:0] dly;
		logic [TONE_W-1:0] tone_cnt;
		logic tone_ph;
		logic pin_q;
		logic tone;
		logic active;
	} sec_state_t;

	sec_state_t cur;
	sec_state_t next_cur;
	key_mode_t mode;
	logic edge_seen;
	logic keyed;
	logic [DLY_W-1:0] start_cyc;
	logic [DLY_W-1:0] stop_cyc;

	// Mode decode from the two settings bits
	always_comb begin
		if (!i_enable || !i_tone_output_on) begin
			mode = MODE_OFF;
		end else if (i_external_wave_select) begin
			mode = MODE_EXT_WAVE;
		end else begin
			mode = MODE_ENVELOPE;
		end
	end

	// Activity: any pin edge in wave mode, a high pin in envelope mode
	assign edge_seen = i_tone_keying_pin ^ cur.pin_q;
	assign keyed = (mode == MODE_EXT_WAVE) ? edge_seen : i_tone_keying_pin;
	assign start_cyc = (mode == MODE_EXT_WAVE) ? DLY_W'(EXT_START_CYC) : DLY_W'(ENV_START_CYC);
	assign stop_cyc = (mode == MODE_EXT_WAVE) ? DLY_W'(EXT_STOP_CYC) : DLY_W'(ENV_STOP_CYC);

	// Next-state logic; a fresh activity always restarts the stop timer
	always_comb begin
		next_cur = cur;
		next_cur.pin_q = i_tone_keying_pin;
		// Free-running internal tone, only used in envelope mode
		if (cur.tone_cnt >= TONE_W'(TONE_HALF_CYC - 1)) begin
			next_cur.tone_cnt = TONE_ZERO;
			next_cur.tone_ph = ~cur.tone_ph;
		end else begin
			next_cur.tone_cnt = cur.tone_cnt + TONE_ONE;
		end
		case (cur.state)
			TS_IDLE: begin
				next_cur.dly = DLY_ZERO;
				if (mode != MODE_OFF && keyed) begin
					next_cur.state = TS_STARTING;
					next_cur.dly = DLY_ONE;
				end
			end
			TS_STARTING: begin
				if (mode == MODE_OFF || (mode == MODE_ENVELOPE && !keyed)) begin
					next_cur.state = TS_IDLE;
				end else if (cur.dly >= start_cyc) begin
					next_cur.state = TS_ACTIVE;
					next_cur.dly = DLY_ZERO;
				end else begin
					next_cur.dly = cur.dly + DLY_ONE;
				end
			end
			TS_ACTIVE: begin
				next_cur.dly = DLY_ZERO;
				if (mode == MODE_OFF) begin
					next_cur.state = TS_IDLE;
				end else if (mode == MODE_EXT_WAVE && !keyed) begin
					next_cur.state = TS_STOPPING;
					next_cur.dly = DLY_ONE;
				end else if (mode == MODE_ENVELOPE && !keyed) begin
					next_cur.state = TS_STOPPING;
					next_cur.dly = DLY_ONE;
				end
			end
			TS_STOPPING: begin
				if (mode == MODE_OFF) begin
					next_cur.state = TS_IDLE;
				end else if (keyed) begin
					next_cur.state = TS_ACTIVE;
					next_cur.dly = DLY_ZERO;
				end else if (cur.dly >= stop_cyc) begin
					next_cur.state = TS_IDLE;
					next_cur.dly = DLY_ZERO;
				end else begin
					next_cur.dly = cur.dly + DLY_ONE;
				end
			end
			default: begin
				next_cur.state = TS_IDLE;
			end
		endcase
		// Output: pin level in wave mode, internal tone in envelope mode
		next_cur.active = (next_cur.state == TS_ACTIVE) || (next_cur.state == TS_STOPPING);
		if (!next_cur.active || mode == MODE_OFF) begin
			next_cur.tone = 1'b0;
			next_cur.active = 1'b0;
		end else if (mode == MODE_EXT_WAVE) begin
			next_cur.tone = i_tone_keying_pin;
		end else begin
			next_cur.tone = next_cur.tone_ph;
		end
	end

	// State register; lockout clears everything like reset
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !i_enable) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign o_tone = cur.tone;
	assign o_tone_active = cur.active;

endmodule : tone_key_section

// file: core/tone_keying_pkg.sv
// Package: constants and types shared by the tone keying control
package tone_keying_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_HZ = 40000000;
	localparam int NS_PER_S = 1000000000;
	localparam int CLK_PERIOD_NS = NS_PER_S / CLK_HZ;

	// External-wave start delay, 1 us (least: round up)
	localparam int EXT_START_NS = 1000;
	localparam int EXT_START_CYC = (EXT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// External-wave stop after wave ceases, 60 us
	localparam int EXT_STOP_NS = 60000;
	localparam int EXT_STOP_CYC = EXT_STOP_NS / CLK_PERIOD_NS;
	// Envelope start delay, 6 us
	localparam int ENV_START_NS = 6000;
	localparam int ENV_START_CYC = (ENV_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Envelope stop window 15..60 us; the block stops at the least figure
	localparam int ENV_STOP_MIN_NS = 15000;
	localparam int ENV_STOP_MAX_NS = 60000;
	localparam int ENV_STOP_CYC = (ENV_STOP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Soft-start ramp, 4 ms
	localparam int SOFT_START_US = 4000;
	localparam int NS_PER_US = 1000;
	localparam int SOFT_START_CYC = (SOFT_START_US * NS_PER_US) / CLK_PERIOD_NS;
	// Internal 22 kHz tone: half period in cycles
	localparam int TONE_HZ = 22000;
	localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int DLY_W = 12;
	localparam int RAMP_W = 18;
	localparam int RAMP_OUT_W = 8;
	localparam int TONE_W = 10;
	localparam int NUM_SECTIONS = 2;

	localparam logic [DLY_W-1:0] DLY_ZERO = 12'h000;
	localparam logic [DLY_W-1:0] DLY_ONE = 12'h001;
	localparam logic [TONE_W-1:0] TONE_ZERO = 10'h000;
	localparam logic [TONE_W-1:0] TONE_ONE = 10'h001;
	localparam logic [RAMP_W-1:0] RAMP_ZERO = 18'h00000;
	localparam logic [RAMP_W-1:0] RAMP_ONE = 18'h00001;

	// Keying modes
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_EXT_WAVE,
		MODE_ENVELOPE
	} key_mode_t;

	// Per-section tone state
	typedef enum logic [1:0] {
		TS_IDLE,
		TS_STARTING,
		TS_ACTIVE,
		TS_STOPPING
	} tone_state_t;

endpackage : tone_keying_pkg

// file: test/keying_source_model.sv
// Model: receiver demodulator driving one tone keying pin
`timescale 1ns/1ps
module keying_source_model
	import tone_keying_pkg::*;
(
	// Clock
	input wire logic i_sys_clk,
	// Pattern: 0 low, 1 square wave, 2 held high
	input wire logic [1:0] i_mode,
	// Keying pin
	output logic o_pin = 1'b0
);
	logic [TONE_W-1:0] half_cnt = TONE_ZERO;
	// Square wave at the tone rate; first edge at once, so latency is measurable
	always @(posedge i_sys_clk) begin
		half_cnt <= (i_mode != 2'h1 || half_cnt == TONE_W'(TONE_HALF_CYC - 1)) ?
			TONE_ZERO : half_cnt + TONE_ONE;
		if (i_mode == 2'h1) begin
			o_pin <= (half_cnt == TONE_ZERO) ? ~o_pin : o_pin;
		end else begin
			o_pin <= (i_mode == 2'h2);
		end
	end
endmodule : keying_source_model

// file: test/lnb_tone_keying_control_asserts.sv
// Checker: port relations of the tone keying control
`timescale 1ns/1ps
module lnb_tone_keying_control_asserts
	import tone_keying_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// Inputs
	input wire logic i_supply_lockout,
	input wire logic i_settings_write,
	input wire logic [1:0] i_external_wave_select,
	input wire logic [1:0] i_tone_output_on,
	input wire logic [1:0] i_tone_keying_pin,
	// Outputs
	input wire logic [1:0] o_lnb_supply_output_tone,
	input wire logic [1:0] o_tone_active,
	input wire logic [1:0] o_external_wave_select,
	input wire logic [1:0] o_tone_output_on,
	input wire logic [7:0] o_soft_start_level,
	input wire logic o_soft_start_done
);
	// ********
	// Relations
	// ********
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// Section A mode decode; B is the same logic
	wire wave_a = o_external_wave_select[0] & o_tone_output_on[0];
	wire env_a = ~o_external_wave_select[0] & o_tone_output_on[0];
	wire act_a = o_tone_active[0];
	wire pin_a = i_tone_keying_pin[0];
	sequence wave_edge;
		wave_a && act_a ##0 $changed(pin_a);
	endsequence
	sequence env_end;
		env_a && act_a ##0 $fell(pin_a);
	endsequence
	chk_lockout_clears: assert property (
		i_supply_lockout |=> {o_tone_active, o_lnb_supply_output_tone,
		o_tone_output_on, o_external_wave_select} == 8'h00) else $error("lockout left state");
	chk_write_taken: assert property (
		i_settings_write && !i_supply_lockout |=> o_tone_output_on == $past(i_tone_output_on)
		&& o_external_wave_select == $past(i_external_wave_select)) else $error("bad readback");
	chk_tone_off: assert property (
		(o_lnb_supply_output_tone & ~o_tone_output_on & ~$past(o_tone_output_on)) == 2'h0)
		else $error("tone while disabled");
	chk_tone_gated: assert property (
		(o_lnb_supply_output_tone & ~o_tone_active & ~$past(o_tone_active)) == 2'h0)
		else $error("tone while inactive");
	chk_wave_follow: assert property (
		wave_a && act_a && $past(wave_a && act_a) |-> o_lnb_supply_output_tone[0] == $past(pin_a))
		else $error("tone not following pin");
	chk_wave_hold: assert property (
		wave_edge |=> act_a [*8]) else $error("wave hold too short");
	chk_env_hold: assert property (
		env_end |=> act_a [*8]) else $error("envelope hold too short");
	chk_env_start: assert property (
		$rose(act_a) && env_a |-> $past(pin_a, ENV_START_CYC - 1)) else $error("early start");
	chk_ramp_rises: assert property (
		!i_supply_lockout && !$past(i_supply_lockout) |-> o_soft_start_level >=
		$past(o_soft_start_level)) else $error("ramp fell");
	chk_done_full: assert property (
		o_soft_start_done |-> o_soft_start_level == 8'hff) else $error("done below full");
endmodule : lnb_tone_keying_control_asserts
bind lnb_tone_keying_control lnb_tone_keying_control_asserts u_checker (.*);

// file: test/lnb_tone_keying_control_tb.sv
// Testbench: tone keying control against two keying source models
`timescale 1ns/1ps
module lnb_tone_keying_control_tb;
	import tone_keying_pkg::*;
	// ********
	// Signals
	// ********
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_supply_lockout = 1'b0;
	logic i_settings_write = 1'b0;
	logic [1:0] i_external_wave_select = 2'h0;
	logic [1:0] i_tone_output_on = 2'h0;
	wire [1:0] i_tone_keying_pin; // One model drives each bit
	logic [1:0] o_lnb_supply_output_tone, o_tone_active;
	logic [1:0] o_external_wave_select, o_tone_output_on;
	logic [7:0] o_soft_start_level;
	logic o_soft_start_done;
	logic [3:0] modes = 4'h0;
	logic last;
	int errors = 0;
	int total_checks = 0;
	int seed = 21928;
	int n, k, r;
	int cyc = 0;
	// Clock and cycle count since reset
	always #12.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) cyc <= i_reset ? 0 : cyc + 1;
	lnb_tone_keying_control DUT (.*);
	keying_source_model src_a (.i_sys_clk(i_sys_clk), .i_mode(modes[1:0]),
		.o_pin(i_tone_keying_pin[0]));
	keying_source_model src_b (.i_sys_clk(i_sys_clk), .i_mode(modes[3:2]),
		.o_pin(i_tone_keying_pin[1]));
	// ********
	// Tasks
	// ********
	task automatic rng(input string nm, input int v, input int lo, input int hi);
		total_checks++;
		if (v < lo || v > hi) begin
			errors++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask : rng
	task automatic eq(input string nm, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : eq
	// Lockout wipes settings, so a write under it reads back zero
	function automatic logic [1:0] rb(input logic lk, input logic [1:0] v);
		return lk ? 2'h0 : v;
	endfunction : rb
	task automatic wr(input logic [1:0] e, input logic [1:0] t);
		@(posedge i_sys_clk);
		i_settings_write <= 1'b1;
		i_external_wave_select <= e;
		i_tone_output_on <= t;
		@(posedge i_sys_clk);
		i_settings_write <= 1'b0;
		#1;
	endtask : wr
	task automatic go(input int s, input logic [1:0] m);
		@(posedge i_sys_clk);
		modes[2*s+:2] <= m;
		@(posedge i_sys_clk);
		#1;
	endtask : go
	task automatic wt(input int s, input logic v, input int lim);
		n = 0;
		while (o_tone_active[s] !== v && n < lim) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
	endtask : wt
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict
	// Watchdog: the tests need about two fifths of this span
	initial begin
		#(40000 * 25);
		errors++;
		$display("[FAIL] run time expected end seen hang");
		give_verdict();
	end
	// ********
	// Tests
	// ********
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		@(posedge i_sys_clk);
		#1;
		eq("reset tone", {4'h0, o_tone_active, o_lnb_supply_output_tone}, 8'h00);
		eq("reset set", {4'h0, o_tone_output_on, o_external_wave_select}, 8'h00);
		eq("ramp start", o_soft_start_level, 8'h00);
		for (int s = 0; s < 2; s++) begin
			wr(2'h1 << s, 2'h1 << s);
			go(s, 2'h1);
			wt(s, 1'b1, 100);
			rng("wave start", n, EXT_START_CYC, EXT_START_CYC + 3);
			repeat (2000) @(posedge i_sys_clk);
			// Look at the settled pin, not the value before this edge
			#1;
			wait (i_tone_keying_pin[s] === 1'b1);
			go(s, 2'h0);
			wt(s, 1'b0, 3000);
			rng("wave stop", n, EXT_STOP_CYC - 1, EXT_STOP_CYC + 3);
			wr(2'h0, 2'h1 << s);
			go(s, 2'h2);
			wt(s, 1'b1, 400);
			rng("env start", n, ENV_START_CYC, ENV_START_CYC + 3);
			last = o_lnb_supply_output_tone[s];
			k = 0;
			repeat (2000) begin
				@(posedge i_sys_clk);
				#1;
				k += int'(o_lnb_supply_output_tone[s] !== last);
				last = o_lnb_supply_output_tone[s];
			end
			rng("env tone edges", k, 2, 3);
			eq("other idle", {7'h00, o_tone_active[1-s]}, 8'h00);
			go(s, 2'h0);
			wt(s, 1'b0, 1000);
			rng("env stop", n, ENV_STOP_CYC - 1, ENV_STOP_CYC + 3);
			wr(2'h0, 2'h0);
			go(s, 2'h2);
			repeat (400) @(posedge i_sys_clk);
			#1;
			eq("tone disabled", {6'h00, o_tone_active}, 8'h00);
			go(s, 2'h0);
			$display("section %0d tests done", s);
		end
		rng("ramp level", o_soft_start_level, (cyc >> 10) - 2, (cyc >> 10) + 2);
		eq("ramp not done", {7'h00, o_soft_start_done}, 8'h00);
		// Lockout during a running tone: tone stops, settings clear, ramp restarts
		wr(2'h0, 2'h1);
		go(0, 2'h2);
		wt(0, 1'b1, 400);
		eq("tone before lockout", {7'h00, o_tone_active[0]}, 8'h01);
		@(posedge i_sys_clk);
		i_supply_lockout <= 1'b1;
		@(posedge i_sys_clk);
		#1;
		eq("lockout tone", {4'h0, o_tone_active, o_lnb_supply_output_tone}, 8'h00);
		eq("lockout set", {4'h0, o_tone_output_on, o_external_wave_select}, 8'h00);
		eq("lockout ramp", o_soft_start_level, 8'h00);
		@(posedge i_sys_clk);
		i_supply_lockout <= 1'b0;
		go(0, 2'h0);
		$display("lockout test done");
		// Random settings with random lockout
		repeat (8) begin
			r = $random(seed);
			@(posedge i_sys_clk);
			i_supply_lockout <= r[4];
			wr(r[1:0], r[3:2]);
			eq("readback", {4'h0, o_external_wave_select, o_tone_output_on},
				{4'h0, rb(r[4], r[1:0]), rb(r[4], r[3:2])});
		end
		$display("random settings test done");
		give_verdict();
	end
endmodule : lnb_tone_keying_control_tb
